// File: inc/scs_pkg.sv
// Constants, encodings and register map of the system clock source selector
package scs_pkg;

   // -----------------------------------------------------------------
   // Configuration word layout
   // -----------------------------------------------------------------
   localparam int         CFG_MODE_LSB   = 0;
   localparam int         CFG_MODE_W     = 3;
   localparam int         CFG_PWRTE_BIT  = 4;
   localparam int         CFG_INTERNAL_FREQ_SELECT_BIT = 7;
   localparam logic [7:0] CFG_RESET      = 8'h00;

   // -----------------------------------------------------------------
   // Clock mode codes
   // -----------------------------------------------------------------
   localparam logic [2:0] MODE_EXTERNAL_CLOCK = 3'h0;
   localparam logic [2:0] MODE_LOW_GAIN_XTAL  = 3'h1;
   localparam logic [2:0] MODE_MED_GAIN_XTAL  = 3'h2;
   localparam logic [2:0] MODE_HIGH_GAIN_XTAL = 3'h3;
   localparam logic [2:0] MODE_RES_CAP        = 3'h4;
   localparam logic [2:0] MODE_RES_CAP_IO     = 3'h5;
   localparam logic [2:0] MODE_INT_CLOCKOUT   = 3'h6;
   localparam logic [2:0] MODE_INT_PINS_IO    = 3'h7;

   localparam logic [1:0] GAIN_LOW  = 2'h0;
   localparam logic [1:0] GAIN_MED  = 2'h1;
   localparam logic [1:0] GAIN_HIGH = 2'h2;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam int         ADDR_W          = 8;
   localparam logic [7:0] OFFS_CTRL       = 8'h00;
   localparam logic [7:0] OFFS_STATUS     = 8'h04;
   localparam logic [7:0] OFFS_CONFIG     = 8'h08;
   localparam int         CTRL_SLEEP_BIT  = 0;
   localparam int         CTRL_WAKE_BIT   = 1;
   localparam int         CTRL_GPIO_O_LSB = 8;
   localparam int         CTRL_GPIO_E_LSB = 12;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS    = 40;
   localparam int          CLK_FREQ_MHZ     = 25;
   localparam int          POWER_UP_TIMER_TIME_MS     = 64;
   localparam int          POWER_UP_TIMER_CYCLES      = (POWER_UP_TIMER_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int          POWER_UP_TIMER_W           = 21;
   localparam int          INT_OSC_FAST_MHZ = 8;
   localparam int          NCO_W            = 6;
   localparam int          STARTUP_W        = 11;
   localparam logic [10:0] OST_OSCILLATIONS = 11'h400;
   localparam int          RC_DELAY_INSTR   = 2;
   localparam int          TICKS_PER_INSTR  = 4;
   localparam logic [10:0] RC_DELAY_TICKS   = 11'(RC_DELAY_INSTR * TICKS_PER_INSTR);
   localparam logic [10:0] INT_WARM_TICKS   = 11'h010;
   localparam logic [10:0] EXT_DELAY_TICKS  = 11'h000;

endpackage

// File: inc/scs_start_if.sv
// Link between the selector core and its start-up counter
`timescale 1ns/1ps
interface scs_start_if;
   import scs_pkg::*;
   logic                 start;
   logic                 tick;
   logic [STARTUP_W-1:0] limit;
   logic                 busy;
   logic                 done;

   modport ctrl  (output start, output tick, output limit, input busy, input done);
   modport timer (input start, input tick, input limit, output busy, output done);
endinterface

// File: core/scs_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module scs_pin_sync #(
   parameter int W = 3
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A change counts only once the last two stages agree
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dout <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               dout[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule

// File: core/scs_startup_timer.sv
// Start-up delay counter cleared on each start request
`timescale 1ns/1ps
module scs_startup_timer (
   input  wire logic clk,
   input  wire logic reset_n,
   scs_start_if.timer su
);
   import scs_pkg::*;

   logic [STARTUP_W-1:0] cnt_reg;
   logic                 busy_reg;
   logic                 done_reg;

   assign su.busy = busy_reg;
   assign su.done = done_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg  <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (su.start) begin
         cnt_reg  <= '0;
         busy_reg <= (su.limit != '0);
         done_reg <= (su.limit == '0);
      end else if (busy_reg && su.tick) begin
         cnt_reg <= cnt_reg + 11'h001;
         if (cnt_reg + 11'h001 == su.limit) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
         end
      end
   end
endmodule

// File: core/scs_clock_selector.sv
// System clock source selector with start-up sequencing and register slave
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module scs_clock_selector #(
   parameter int POWER_UP_TIMER_LIMIT = scs_pkg::POWER_UP_TIMER_CYCLES
) (
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   input  wire logic [7:0]                 cfg_word,
   input  wire logic                       osc_in_i,
   output logic                            osc_in_o,
   output logic                            osc_in_oe,
   input  wire logic                       osc_out_i,
   output logic                            osc_out_o,
   output logic                            osc_out_oe,
   input  wire logic                       wake_i,
   output logic                            sys_tick,
   output logic                            cpu_run,
   output logic                            amp_enable,
   output logic [1:0]                      amp_gain,
   input  wire logic [scs_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [scs_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready
);
   import scs_pkg::*;

   typedef enum logic [2:0] {
      ST_CFG, ST_POWER_UP_TIMER, ST_START, ST_RUN, ST_SLEEP
   } scs_state_e;

   // -----------------------------------------------------------------
   // Mode decoding helpers
   // -----------------------------------------------------------------
   function automatic logic is_crystal(input logic [2:0] m);
      return (m == MODE_LOW_GAIN_XTAL) || (m == MODE_MED_GAIN_XTAL) ||
             (m == MODE_HIGH_GAIN_XTAL);
   endfunction

   function automatic logic is_internal(input logic [2:0] m);
      return (m == MODE_INT_CLOCKOUT) || (m == MODE_INT_PINS_IO);
   endfunction

   function automatic logic [STARTUP_W-1:0] startup_limit(input logic [2:0] m);
      if (is_crystal(m)) begin
         return OST_OSCILLATIONS;
      end else if (is_internal(m)) begin
         return INT_WARM_TICKS;
      end else if (m == MODE_EXTERNAL_CLOCK) begin
         return EXT_DELAY_TICKS;
      end else begin
         return RC_DELAY_TICKS;
      end
   endfunction

   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      if (a == OFFS_CTRL) begin
         return 1'b1;
      end else if (a == OFFS_STATUS) begin
         return 1'b1;
      end else if (a == OFFS_CONFIG) begin
         return 1'b1;
      end else begin
         return 1'b0;
      end
   endfunction

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   scs_start_if su ();

   scs_state_e        state_reg;
   logic [7:0]        cfg_reg;
   logic [2:0]        mode;
   logic              fast_sel;
   logic [2:0]        pin_s;
   logic              osc_prev_reg;
   logic              ext_edge;
   logic [NCO_W-1:0]  nco_reg;
   logic [NCO_W-1:0]  nco_sum;
   logic              nco_tick;
   logic              post_reg;
   logic              src_tick;
   logic              start_reg;
   logic [POWER_UP_TIMER_W-1:0] power_up_timer_cnt_reg;
   logic              div_reg;
   logic              divided_clock_output_reg;
   logic              sleep_cmd_reg;
   logic              wake_cmd_reg;
   logic [1:0]        gpio_o_reg;
   logic [1:0]        gpio_e_reg;
   logic              aw_hold_reg;
   logic              w_hold_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0]       wdata_reg;
   logic [3:0]        wstrb_reg;
   logic              wr_commit;
   logic [31:0]       status_word;

   assign mode     = cfg_reg[CFG_MODE_LSB +: CFG_MODE_W];
   assign fast_sel = cfg_reg[CFG_INTERNAL_FREQ_SELECT_BIT];

   scs_pin_sync #(
      .W (3)
   ) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .din     ({wake_i, osc_out_i, osc_in_i}),
      .dout    (pin_s)
   );

   scs_startup_timer u_timer (
      .clk     (clk),
      .reset_n (reset_n),
      .su      (su.timer)
   );

   // -----------------------------------------------------------------
   // Clock source ticks
   // -----------------------------------------------------------------
   assign ext_edge = pin_s[0] && !osc_prev_reg;
   assign nco_sum  = nco_reg + NCO_W'(INT_OSC_FAST_MHZ);
   assign nco_tick = (nco_sum >= NCO_W'(CLK_FREQ_MHZ));

   // Internal source: 8 MHz directly, 4 MHz through the postscaler
   always_comb begin
      if (is_internal(mode)) begin
         src_tick = fast_sel ? nco_tick : (nco_tick && post_reg);
      end else begin
         src_tick = ext_edge;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_prev_reg <= 1'b0;
         nco_reg      <= '0;
         post_reg     <= 1'b0;
      end else begin
         osc_prev_reg <= pin_s[0];
         nco_reg      <= nco_tick ? NCO_W'(nco_sum - NCO_W'(CLK_FREQ_MHZ)) : nco_sum;
         if (nco_tick) begin
            post_reg <= !post_reg;
         end
      end
   end

   assign su.start = start_reg;
   assign su.tick  = src_tick;
   assign su.limit = startup_limit(mode);

   // -----------------------------------------------------------------
   // Start-up sequencing
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg    <= ST_CFG;
         cfg_reg      <= CFG_RESET;
         start_reg    <= 1'b0;
         power_up_timer_cnt_reg <= '0;
      end else begin
         start_reg <= 1'b0;
         case (state_reg)
            ST_CFG: begin
               cfg_reg <= cfg_word;
               if (cfg_word[CFG_PWRTE_BIT]) begin
                  state_reg <= ST_POWER_UP_TIMER;
               end else begin
                  start_reg <= 1'b1;
                  state_reg <= ST_START;
               end
            end
            ST_POWER_UP_TIMER: begin
               power_up_timer_cnt_reg <= power_up_timer_cnt_reg + 21'h000001;
               if (power_up_timer_cnt_reg == POWER_UP_TIMER_W'(POWER_UP_TIMER_LIMIT - 1)) begin
                  start_reg <= 1'b1;
                  state_reg <= ST_START;
               end
            end
            ST_START: begin
               if (!start_reg && su.done) begin
                  state_reg <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (sleep_cmd_reg) begin
                  state_reg <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (wake_cmd_reg || pin_s[2]) begin
                  start_reg <= 1'b1;
                  state_reg <= ST_START;
               end
            end
            default: begin
               state_reg <= ST_CFG;
            end
         endcase
      end
   end

   // Execution advances only on source ticks while running
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sys_tick <= 1'b0;
         cpu_run  <= 1'b0;
      end else begin
         sys_tick <= src_tick && (state_reg == ST_RUN);
         cpu_run  <= (state_reg == ST_RUN);
      end
   end

   // Fosc/4 output: toggles every second oscillator tick
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_reg    <= 1'b0;
         divided_clock_output_reg <= 1'b0;
      end else if (src_tick && (state_reg != ST_SLEEP)) begin
         div_reg <= !div_reg;
         if (div_reg) begin
            divided_clock_output_reg <= !divided_clock_output_reg;
         end
      end
   end

   // -----------------------------------------------------------------
   // Pin functions and amplifier gain
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_in_o   <= 1'b0;
         osc_in_oe  <= 1'b0;
         osc_out_o  <= 1'b0;
         osc_out_oe <= 1'b0;
         amp_enable <= 1'b0;
         amp_gain   <= GAIN_LOW;
      end else begin
         osc_in_o   <= 1'b0;
         osc_in_oe  <= 1'b0;
         osc_out_o  <= 1'b0;
         osc_out_oe <= 1'b0;
         amp_enable <= is_crystal(mode);
         amp_gain   <= GAIN_LOW;
         case (mode)
            MODE_EXTERNAL_CLOCK, MODE_RES_CAP_IO: begin
               osc_out_o  <= gpio_o_reg[1];
               osc_out_oe <= gpio_e_reg[1];
            end
            MODE_RES_CAP: begin
               osc_out_o  <= divided_clock_output_reg;
               osc_out_oe <= 1'b1;
            end
            MODE_INT_CLOCKOUT: begin
               osc_out_o  <= divided_clock_output_reg;
               osc_out_oe <= 1'b1;
               osc_in_o   <= gpio_o_reg[0];
               osc_in_oe  <= gpio_e_reg[0];
            end
            MODE_INT_PINS_IO: begin
               osc_out_o  <= gpio_o_reg[1];
               osc_out_oe <= gpio_e_reg[1];
               osc_in_o   <= gpio_o_reg[0];
               osc_in_oe  <= gpio_e_reg[0];
            end
            MODE_MED_GAIN_XTAL: begin
               amp_gain <= GAIN_MED;
            end
            MODE_HIGH_GAIN_XTAL: begin
               amp_gain <= GAIN_HIGH;
            end
            default: begin
               amp_gain <= GAIN_LOW;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // AXI4-Lite write path
   // -----------------------------------------------------------------
   assign wr_commit = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_hold_reg   <= 1'b0;
         awaddr_reg    <= '0;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_reg   <= 1'b1;
         awaddr_reg    <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         aw_hold_reg <= 1'b0;
      end else begin
         s_axi_awready <= !aw_hold_reg && !s_axi_bvalid;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         w_hold_reg   <= 1'b0;
         wdata_reg    <= '0;
         wstrb_reg    <= '0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_reg   <= 1'b1;
         wdata_reg    <= s_axi_wdata;
         wstrb_reg    <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         w_hold_reg <= 1'b0;
      end else begin
         s_axi_wready <= !w_hold_reg && !s_axi_bvalid;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_commit) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= addr_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control register: sleep and wake are self-clearing commands
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sleep_cmd_reg <= 1'b0;
         wake_cmd_reg  <= 1'b0;
         gpio_o_reg    <= 2'h0;
         gpio_e_reg    <= 2'h0;
      end else begin
         sleep_cmd_reg <= 1'b0;
         wake_cmd_reg  <= 1'b0;
         if (wr_commit && (awaddr_reg == OFFS_CTRL)) begin
            if (wstrb_reg[0]) begin
               sleep_cmd_reg <= wdata_reg[CTRL_SLEEP_BIT];
               wake_cmd_reg  <= wdata_reg[CTRL_WAKE_BIT];
            end
            if (wstrb_reg[1]) begin
               gpio_o_reg <= wdata_reg[CTRL_GPIO_O_LSB +: 2];
               gpio_e_reg <= wdata_reg[CTRL_GPIO_E_LSB +: 2];
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // AXI4-Lite read path
   // -----------------------------------------------------------------
   assign status_word = {16'h0000, (state_reg != ST_CFG), pin_s,
                         divided_clock_output_reg, (state_reg == ST_SLEEP), su.busy, cpu_run,
                         3'h0, cfg_reg[CFG_PWRTE_BIT], fast_sel, mode};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         if (s_axi_araddr == OFFS_CTRL) begin
            s_axi_rdata <= {18'h00000, gpio_e_reg, 2'h0, gpio_o_reg, 8'h00};
         end else if (s_axi_araddr == OFFS_STATUS) begin
            s_axi_rdata <= status_word;
         end else if (s_axi_araddr == OFFS_CONFIG) begin
            s_axi_rdata <= {24'h000000, cfg_reg};
         end else begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid;
      end
   end
endmodule

// File: tb/scs_osc_model.sv
// Oscillator stand-in on the oscillator input pin
`timescale 1ns/1ps
module scs_osc_model #(
   parameter int HALF_NS = 130
) (
   input  wire logic run,
   output logic      osc
);
   initial osc = 1'b0;
   // Toggles only while enabled, stands still otherwise
   always begin
      #(HALF_NS);
      if (run) osc = ~osc;
   end
endmodule

// File: tb/scs_clock_selector_checker.sv
// Port-level assertions for the clock source selector
`timescale 1ns/1ps
module scs_clock_selector_checker (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic [7:0] cfg_word,
   input wire logic       osc_in_i,
   input wire logic       osc_in_oe,
   input wire logic       osc_out_o,
   input wire logic       osc_out_oe,
   input wire logic       sys_tick,
   input wire logic       cpu_run,
   input wire logic       amp_enable,
   input wire logic [1:0] amp_gain
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire [2:0] m = cfg_word[2:0];
   wire xtal = (m != 3'h0) && (m < 3'h4);
   wire clko = (m == 3'h4) || (m == 3'h6);
   logic [11:0] edges;
   logic [2:0]  tk;
   logic        pin, pout, seen;
   // Raw input edges since reset and system ticks between output toggles
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         edges <= 12'h000;
         tk <= 3'h0;
         pin <= 1'b0;
         pout <= 1'b0;
         seen <= 1'b0;
      end else begin
         pin <= osc_in_i;
         pout <= osc_out_o;
         seen <= cpu_run && (seen || osc_out_o != pout);
         if (osc_in_i && !pin && edges != 12'hFFF) edges <= edges + 12'h001;
         if (!cpu_run || osc_out_o != pout) tk <= 3'h0;
         else if (sys_tick && tk != 3'h7) tk <= tk + 3'h1;
      end
   end
   property p_gain;
      cpu_run |-> amp_enable == xtal && (!xtal || amp_gain == m[1:0] - 2'h1);
   endproperty
   a_gain: assert property (p_gain) else $error("amplifier gain wrong");
   property p_in_pin;
      cpu_run && m < 3'h6 |-> !osc_in_oe;
   endproperty
   a_in_pin: assert property (p_in_pin) else $error("input pin driven");
   property p_divided_clock_output;
      cpu_run && clko |-> osc_out_oe;
   endproperty
   a_divided_clock_output: assert property (p_divided_clock_output) else $error("clock output off");
   property p_div;
      cpu_run && seen && clko && osc_out_o != pout |-> tk + 3'(sys_tick) == 3'h2;
   endproperty
   a_div: assert property (p_div) else $error("clock output not quarter rate");
   property p_tick;
      sys_tick |-> cpu_run;
   endproperty
   a_tick: assert property (p_tick) else $error("tick while halted");
   property p_ext;
      $rose(reset_n) && m == 3'h0 && !cfg_word[4] |-> ##[1:10] cpu_run;
   endproperty
   a_ext: assert property (p_ext) else $error("external start delayed");
   property p_xtal;
      $rose(cpu_run) && xtal |-> edges >= 12'h400 && edges <= 12'h403;
   endproperty
   a_xtal: assert property (p_xtal) else $error("crystal start count wrong");
   property p_rc;
      $rose(cpu_run) && (m == 3'h4 || m == 3'h5) |-> edges >= 12'h008 && edges <= 12'h00B;
   endproperty
   a_rc: assert property (p_rc) else $error("rc start delay wrong");
   property p_stop;
      (m < 3'h6 && $stable(osc_in_i)) [*8] |-> !sys_tick;
   endproperty
   a_stop: assert property (p_stop) else $error("tick without clock");
endmodule

bind scs_clock_selector scs_clock_selector_checker u_scs_clock_selector_checker (.*);

// File: tb/scs_clock_selector_test.sv
// Self-checking bench for the clock source selector
`timescale 1ns/1ps
module scs_clock_selector_test;
   import scs_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, osc_run = 1'b0, wake_i = 1'b0;
   logic [7:0] cfg_word = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic wave, osc_in_i, osc_in_o, osc_in_oe, osc_out_i, osc_out_o, osc_out_oe;
   logic sys_tick, cpu_run, amp_enable;
   logic [1:0] amp_gain, s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int failures = 0, compares = 0, cyc = 0;

   always #20 clk = ~clk;
   assign osc_in_i = osc_in_oe ? osc_in_o : wave;
   assign osc_out_i = osc_out_oe ? osc_out_o : 1'b1;
   scs_osc_model u_scs_osc_model (.run(osc_run), .osc(wave));
   scs_clock_selector #(.POWER_UP_TIMER_LIMIT(20)) u_scs_clock_selector (.*);

   task automatic close_out;
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic ha, hw, hr, hd;
      int n;
      hd = 1'b0;
      n = 0;
      @(posedge clk);
      if (wr) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
      end
      while (!hd && n < 200) begin
         @(negedge clk);
         n++;
         ha = s_axi_awvalid && s_axi_awready;
         hw = s_axi_wvalid && s_axi_wready;
         hr = s_axi_arvalid && s_axi_arready;
         hd = wr ? s_axi_bvalid : s_axi_rvalid;
         q = s_axi_rdata;
         r = wr ? s_axi_bresp : s_axi_rresp;
         @(posedge clk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         if (hr) s_axi_arvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (!hd) failures++;
   endtask

   task automatic boot(input logic [7:0] c);
      int n;
      n = 0;
      @(posedge clk);
      reset_n <= 1'b0;
      cfg_word <= c;
      osc_run <= 1'b1;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      while (!cpu_run && n < 9000) begin
         @(negedge clk);
         n++;
      end
      if (c[CFG_PWRTE_BIT]) chk(32'(n > 20), 32'h1);
      chk(32'(cpu_run), 32'h1);
   endtask

   task automatic cnt(input int len, output int n);
      n = 0;
      repeat (len) begin
         @(negedge clk);
         if (sys_tick) n++;
      end
   endtask

   task automatic t_modes;
      logic [2:0] m;
      for (int i = 0; i < 8; i++) begin
         m = 3'(i);
         boot({5'h00, m});
         axi(1'b0, OFFS_STATUS, 32'h0);
         chk({29'h0, q[2:0]}, {29'h0, m});
         axi(1'b0, OFFS_CONFIG, 32'h0);
         chk({24'h0, q[7:0]}, {29'h0, m});
         chk(32'(amp_enable), 32'(m inside {3'h1, 3'h2, 3'h3}));
         chk({osc_in_oe, osc_out_oe}, {1'b0, m == 3'h4 || m == 3'h6});
      end
   endtask

   task automatic t_bad;
      axi(1'b0, 8'h0C, 32'h0);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      chk(q, 32'h0);
   endtask

   task automatic t_gpio;
      boot(8'h07);
      axi(1'b1, OFFS_CTRL, 32'h0000_3300);
      repeat (3) @(negedge clk);
      chk({osc_in_oe, osc_in_o, osc_out_oe, osc_out_o}, 4'hF);
   endtask

   task automatic t_stop;
      int n;
      boot(8'h10);
      axi(1'b1, OFFS_CTRL, 32'h0000_0001);
      repeat (3) @(negedge clk);
      cnt(20, n);
      chk(32'(n), 32'h0);
      chk(32'(cpu_run), 32'h0);
      @(posedge clk);
      wake_i <= 1'b1;
      repeat (10) @(negedge clk);
      chk(32'(cpu_run), 32'h1);
      @(posedge clk);
      wake_i <= 1'b0;
      osc_run <= 1'b0;
      repeat (10) @(negedge clk);
      cnt(100, n);
      chk(32'(n), 32'h0);
      chk(32'(cpu_run), 32'h1);
      @(posedge clk);
      osc_run <= 1'b1;
      cnt(100, n);
      chk(32'(n > 0), 32'h1);
   endtask

   task automatic t_fast;
      int n;
      boot(8'h86);
      cnt(500, n);
      chk(32'(n >= 159 && n <= 161), 32'h1);
      boot(8'h07);
      cnt(500, n);
      chk(32'(n >= 79 && n <= 81), 32'h1);
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         failures++;
         close_out();
      end
   end

   initial begin
      t_modes();
      t_bad();
      t_gpio();
      t_stop();
      t_fast();
      close_out();
   end
endmodule
